// ===== rtl/tcs_pkg.sv
package tcs_pkg;
    localparam int IR_BITS = 6;
    localparam int CFG_DR_BITS = 64;
    localparam int WORD_BITS = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int SEQ_TCK_CYCLES = 12;
    localparam logic [3:0] SEQ_LAST = 4'hc;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1f;
    localparam logic [2:0] MODE_TAP_CONFIG = 3'h5;
    // Opcodes as shifted, first bit shifted sits in bit 0
    localparam logic [IR_BITS-1:0] IR_CFG_LOAD = 6'h14;
    localparam logic [IR_BITS-1:0] IR_STARTUP = 6'h06;
    localparam logic [IR_BITS-1:0] IR_SHUTDOWN = 6'h16;
    localparam logic [IR_BITS-1:0] IR_BYPASS = 6'h3f;
    localparam logic [IR_BITS-1:0] IR_CAPTURE = 6'h01;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [15:0] {
        TEST_LOGIC_RESET_STATE = 16'h0001,
        RUN_TEST_IDLE_STATE = 16'h0002,
        SELECT_DR = 16'h0004,
        CAPTURE_DR = 16'h0008,
        SHIFT_DR = 16'h0010,
        EXIT1_DR = 16'h0020,
        PAUSE_DR = 16'h0040,
        EXIT2_DR = 16'h0080,
        UPDATE_DR = 16'h0100,
        SELECT_IR = 16'h0200,
        CAPTURE_IR = 16'h0400,
        SHIFT_IR = 16'h0800,
        EXIT1_IR = 16'h1000,
        PAUSE_IR = 16'h2000,
        EXIT2_IR = 16'h4000,
        UPDATE_IR = 16'h8000
    } tcs_tap_t;
endpackage

// ===== rtl/tcs_stream_if.sv
`timescale 1ns/1ps
interface tcs_stream_if #(parameter int WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/tcs_fifo.sv
`timescale 1ns/1ps
module tcs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rstN,
    tcs_stream_if.snk wr,
    tcs_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic outValid;
    logic [WIDTH-1:0] outData;

    wire push = wr.valid && wr.ready;
    wire load = (count != '0) && (!outValid || rd.ready);
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

    assign wr.ready = count != (AW+1)'(DEPTH);
    assign rd.valid = outValid;
    assign rd.data = outData;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= wr.data;
        end
        if (load) begin
            outData <= mem[rdPtr];
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outValid <= 1'b0;
        end else begin
            wrPtr <= wrPtr + AW'(push);
            rdPtr <= rdPtr + AW'(load);
            count <= next_count;
            outValid <= load || (outValid && !rd.ready);
        end
    end
endmodule

// ===== rtl/tcs_top.sv
`timescale 1ns/1ps
module tcs_top #(
    parameter logic [31:0] SYNC_WORD = 32'h0000_0001,
    parameter logic [31:0] CRC_RESET_CMD = 32'h0000_0002,
    parameter logic [31:0] HOLD_CMD = 32'h0000_0003
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOeN,
    input wire logic programClearN,
    input wire logic modePinHighBit,
    input wire logic modePinMidBit,
    input wire logic modePinLowBit,
    output logic modeStrapOk,
    output logic [tcs_pkg::WORD_BITS-1:0] cfgWord,
    output logic cfgWordValid,
    input wire logic cfgWordReady,
    output logic configDone,
    output logic globalInterconnectHoldN,
    output logic memClear,
    output logic crcReset,
    output logic overrun
);
    import tcs_pkg::*;

    logic [1:0] rstPipe;
    wire rstN = rstPipe[1];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    // Pin synchronisers, stage 0 read only by stage 1
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic tckLast;
    logic progLast;
    wire [7:0] pinsIn = {modePinHighBit, modePinMidBit, modePinLowBit,
                         1'b0, programClearN, tdi, tms, tck};

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            syncA <= 8'h08;
            syncB <= 8'h08;
            tckLast <= 1'b0;
            progLast <= 1'b1;
        end else begin
            syncA <= pinsIn;
            syncB <= syncA;
            tckLast <= syncB[0];
            progLast <= syncB[3];
        end
    end

    wire tckS = syncB[0];
    wire tmsS = syncB[1];
    wire tdiS = syncB[2];
    wire progS = syncB[3];
    wire [2:0] modeS = syncB[7:5];
    wire tckRise = tckS && !tckLast;
    wire tckFall = !tckS && tckLast;
    wire progFall = !progS && progLast;

    // Test-port controller
    tcs_tap_t tapState;
    tcs_tap_t next_tap;

    always_comb begin
        next_tap = tapState;
        case (tapState)
            TEST_LOGIC_RESET_STATE: next_tap = tmsS ? TEST_LOGIC_RESET_STATE : RUN_TEST_IDLE_STATE;
            RUN_TEST_IDLE_STATE: next_tap = tmsS ? SELECT_DR : RUN_TEST_IDLE_STATE;
            SELECT_DR: next_tap = tmsS ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: next_tap = tmsS ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_tap = tmsS ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_tap = tmsS ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_tap = tmsS ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_tap = tmsS ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_tap = tmsS ? SELECT_DR : RUN_TEST_IDLE_STATE;
            SELECT_IR: next_tap = tmsS ? TEST_LOGIC_RESET_STATE : CAPTURE_IR;
            CAPTURE_IR: next_tap = tmsS ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_tap = tmsS ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_tap = tmsS ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_tap = tmsS ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_tap = tmsS ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_tap = tmsS ? SELECT_DR : RUN_TEST_IDLE_STATE;
            default: next_tap = TEST_LOGIC_RESET_STATE;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            tapState <= TEST_LOGIC_RESET_STATE;
        end else if (tckRise) begin
            tapState <= next_tap;
        end
    end

    // Instruction and data registers
    logic [IR_BITS-1:0] irShift;
    logic [IR_BITS-1:0] ir;
    logic [CFG_DR_BITS-1:0] cfgDr;
    logic bypassBit;
    logic [4:0] bitCount;

    wire inShiftIr = tapState == SHIFT_IR;
    wire inShiftDr = tapState == SHIFT_DR;
    wire irCfg = ir == IR_CFG_LOAD;
    wire irStart = ir == IR_STARTUP;
    wire irShut = ir == IR_SHUTDOWN;
    wire drShiftCfg = tckRise && inShiftDr && irCfg;
    wire [WORD_BITS-1:0] newWord = {cfgDr[WORD_BITS-2:0], tdiS};
    wire wordDone = drShiftCfg && bitCount == WORD_LAST_BIT;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            irShift <= IR_CAPTURE;
            ir <= IR_BYPASS;
        end else if (tckRise) begin
            if (tapState == TEST_LOGIC_RESET_STATE) begin
                ir <= IR_BYPASS;
            end
            if (tapState == CAPTURE_IR) begin
                irShift <= IR_CAPTURE;
            end
            if (inShiftIr) begin
                irShift <= {tdiS, irShift[IR_BITS-1:1]};
            end
            if (tapState == UPDATE_IR) begin
                ir <= irShift;
            end
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            cfgDr <= '0;
            bypassBit <= 1'b0;
            bitCount <= 5'h00;
        end else begin
            if (drShiftCfg) begin
                cfgDr <= {cfgDr[CFG_DR_BITS-2:0], tdiS};
                bitCount <= bitCount + 5'h01;
            end
            if (tckRise && tapState == CAPTURE_DR) begin
                bypassBit <= 1'b0;
            end
            if (tckRise && inShiftDr) begin
                bypassBit <= tdiS;
            end
            if (progFall) begin
                bitCount <= 5'h00;
            end
        end
    end

    // TDO changes on falling TCK, enabled only in shift states
    wire drOut = irCfg ? cfgDr[CFG_DR_BITS-1] : bypassBit;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            tdo <= 1'b0;
            tdoOeN <= 1'b1;
        end else if (tckFall) begin
            tdo <= inShiftIr ? irShift[0] : drOut;
            tdoOeN <= !(inShiftIr || inShiftDr);
        end
    end

    // Word stream into the buffer
    tcs_stream_if #(.WIDTH(WORD_BITS)) fillIf ();
    tcs_stream_if #(.WIDTH(WORD_BITS)) drainIf ();

    assign fillIf.valid = wordDone;
    assign fillIf.data = newWord;
    assign cfgWord = drainIf.data;
    assign cfgWordValid = drainIf.valid;
    assign drainIf.ready = cfgWordReady;

    tcs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) wordFifo (
        .clock(clock),
        .rstN(rstN),
        .wr(fillIf),
        .rd(drainIf)
    );

    // Command watch and startup or shutdown sequencing
    logic synced;
    logic [3:0] seqCount;
    logic [1:0] strapWait;

    wire seqTick = tckRise && tapState == RUN_TEST_IDLE_STATE && (irStart || irShut);
    wire seqEnd = seqTick && seqCount == SEQ_LAST - 4'h1;
    wire gotSync = wordDone && newWord == SYNC_WORD;
    wire gotCrcReset = wordDone && synced && newWord == CRC_RESET_CMD;
    wire gotHold = wordDone && synced && newWord == HOLD_CMD;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            synced <= 1'b0;
            seqCount <= 4'h0;
            configDone <= 1'b0;
            globalInterconnectHoldN <= 1'b0;
            memClear <= 1'b0;
            crcReset <= 1'b0;
            overrun <= 1'b0;
            strapWait <= 2'h0;
            modeStrapOk <= 1'b0;
        end else begin
            memClear <= progFall;
            crcReset <= gotCrcReset;
            if (strapWait != STRAP_WAIT) begin
                strapWait <= strapWait + 2'h1;
                modeStrapOk <= modeS == MODE_TAP_CONFIG;
            end
            if (gotSync) begin
                synced <= 1'b1;
            end
            if (gotHold) begin
                globalInterconnectHoldN <= 1'b0;
            end
            if (tckRise && tapState == UPDATE_IR) begin
                seqCount <= 4'h0;
            end else if (seqTick && seqCount != SEQ_LAST) begin
                seqCount <= seqCount + 4'h1;
            end
            if (seqEnd && irStart) begin
                configDone <= 1'b1;
                globalInterconnectHoldN <= 1'b1;
                synced <= 1'b0;
            end
            if (seqEnd && irShut) begin
                configDone <= 1'b0;
                globalInterconnectHoldN <= 1'b0;
            end
            if (progFall) begin
                configDone <= 1'b0;
                globalInterconnectHoldN <= 1'b0;
                synced <= 1'b0;
                overrun <= 1'b0;
            end
            // Lost word wins over a same-cycle clear
            if (wordDone && !fillIf.ready) begin
                overrun <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/tcs_top_assertions.sv
`timescale 1ns/1ps
module tcs_top_assertions
    import tcs_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdoOeN,
    input wire logic programClearN,
    input wire logic [tcs_pkg::WORD_BITS-1:0] cfgWord,
    input wire logic cfgWordValid,
    input wire logic cfgWordReady,
    input wire logic configDone,
    input wire logic globalInterconnectHoldN,
    input wire logic memClear,
    input wire logic crcReset,
    input wire logic overrun
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    stall_hold_a: assert property (cfgWordValid && !cfgWordReady |=> cfgWordValid && $stable(cfgWord))
        else $error("word lost while stalled");
    oe_on_fall_a: assert property ($changed(tdoOeN) |-> !$past(tck) && !$past(tck, 3))
        else $error("tdo enable moved off falling edge");
    tdo_on_fall_a: assert property ($changed(tdo) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo moved off falling edge");
    done_hold_a: assert property ($rose(configDone) |-> globalInterconnectHoldN)
        else $error("startup end without hold release");
    shut_hold_a: assert property ($fell(configDone) |-> !globalInterconnectHoldN)
        else $error("shutdown without hold");
    clear_pulse_a: assert property (memClear |=> !memClear && !configDone)
        else $error("clear pulse wrong");
    clear_cause_a: assert property ($rose(memClear) |-> !programClearN)
        else $error("clear without pin");
    crc_pulse_a: assert property (crcReset |=> !crcReset)
        else $error("crc pulse too long");
    overrun_keep_a: assert property ($fell(overrun) |-> !programClearN)
        else $error("overrun dropped");
    cover property ($rose(configDone));
    cover property (crcReset);
    cover property (overrun && cfgWordValid);
endmodule
bind tcs_top tcs_top_assertions chk (.clock, .resetn, .tck, .tms, .tdo, .tdoOeN,
    .programClearN, .cfgWord, .cfgWordValid, .cfgWordReady, .configDone,
    .globalInterconnectHoldN, .memClear, .crcReset, .overrun);

// ===== tb/tcs_tap_master.sv
`timescale 1ns/1ps
module tcs_tap_master
    import tcs_pkg::*;
(
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    logic [63:0] seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 125 ns test clock, free of the system clock; tdo taken before the rise
    task automatic step(input logic m, input logic d);
        tms <= m;
        tdi <= d;
        #31.25;
        seen = {seen[62:0], tdo};
        #31.25;
        tck <= 1'b1;
        #62.5;
        tck <= 1'b0;
    endtask
    task automatic walk(input logic [15:0] p, input int n);
        for (int i = n - 1; i >= 0; i--) step(p[i], 1'b0);
    endtask
    task automatic load_ir(input logic [IR_BITS-1:0] c);
        walk(16'hc, 4);
        for (int i = 0; i < IR_BITS; i++) step(i == IR_BITS - 1, c[i]);
        walk(16'h2, 2);
    endtask
    task automatic shift_dr(input int n, input logic [63:0] d);
        walk(16'h4, 3);
        for (int i = n - 1; i >= 0; i--) step(i == 0, d[i]);
        walk(16'h2, 2);
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tcs_pkg::*;
    localparam logic [31:0] SW = 32'h0f0f_1001;
    localparam logic [31:0] CR = 32'h0f0f_1002;
    localparam logic [31:0] HC = 32'h0f0f_1003;
    logic clock, resetn, tck, tms, tdi, tdo, tdoOeN, programClearN, cfgWordReady;
    logic modeStrapOk, cfgWordValid, configDone, globalInterconnectHoldN;
    logic memClear, crcReset, overrun, sawCrc, sawClear;
    logic [WORD_BITS-1:0] cfgWord;
    logic [WORD_BITS-1:0] got[$];
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    tcs_top #(.SYNC_WORD(SW), .CRC_RESET_CMD(CR), .HOLD_CMD(HC)) DUT (.clock, .resetn,
        .tck, .tms, .tdi, .tdo, .tdoOeN, .programClearN, .modePinHighBit(1'b1),
        .modePinMidBit(1'b0), .modePinLowBit(1'b1), .modeStrapOk, .cfgWord, .cfgWordValid,
        .cfgWordReady, .configDone, .globalInterconnectHoldN, .memClear, .crcReset,
        .overrun);
    tcs_tap_master M (.tdo(tdoOeN ? 1'b1 : tdo), .tck, .tms, .tdi);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cfgWordValid === 1'b1 && cfgWordReady === 1'b1) got.push_back(cfgWord);
        if (crcReset === 1'b1) sawCrc <= 1'b1;
        if (memClear === 1'b1) sawClear <= 1'b1;
        if (cyc == 40000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic t_reset();
        chk("strap", 1, modeStrapOk);
        chk("oe", 1, tdoOeN);
        chk("hold", 0, globalInterconnectHoldN);
    endtask
    task automatic t_load();
        M.walk(16'h3e, 6);
        M.load_ir(IR_CFG_LOAD);
        M.shift_dr(64, 64'ha5c3_0f96_1234_5678);
        chk("words", 2, got.size());
        chk("word0", 32'ha5c3_0f96, got[0]);
        chk("word1", 32'h1234_5678, got[1]);
        chk("wipe", 0, sawClear);
        got.delete();
    endtask
    task automatic t_start();
        M.load_ir(IR_STARTUP);
        M.walk(16'h0, 11);
        chk("early", 0, configDone);
        M.walk(16'h0, 1);
        chk("done", 1, configDone);
        chk("hold", 1, globalInterconnectHoldN);
        M.walk(16'he, 4);
        chk("run", 1, configDone);
    endtask
    task automatic t_cmds();
        M.load_ir(IR_CFG_LOAD);
        M.shift_dr(64, {SW, HC});
        chk("hold", 0, globalInterconnectHoldN);
        M.shift_dr(64, {SW, CR});
        chk("crc", 1, sawCrc);
        got.delete();
        M.load_ir(IR_SHUTDOWN);
        M.walk(16'h0, 12);
        chk("shut", 0, configDone);
    endtask
    task automatic t_bypass();
        M.load_ir(IR_BYPASS);
        M.shift_dr(8, 64'hb5);
        chk("bypass", 8'h5a, M.seen[9:2]);
        chk("tdoidle", 2'h3, M.seen[1:0]);
        chk("nopush", 0, got.size());
    endtask
    task automatic t_fifo();
        @(posedge clock);
        cfgWordReady <= 1'b0;
        M.load_ir(IR_CFG_LOAD);
        for (int i = 0; i < 18; i += 2) M.shift_dr(64, {32'h100 + i, 32'h101 + i});
        chk("overrun", 1, overrun);
        @(posedge clock);
        cfgWordReady <= 1'b1;
        repeat (40) @(posedge clock);
        chk("kept", 17, got.size());
        chk("first", 32'h100, got[0]);
        chk("last", 32'h110, got[16]);
        got.delete();
    endtask
    task automatic t_clear();
        @(posedge clock);
        programClearN <= 1'b0;
        repeat (10) @(posedge clock);
        programClearN <= 1'b1;
        repeat (6) @(posedge clock);
        chk("wipe", 1, sawClear);
        chk("overrun", 0, overrun);
        chk("done", 0, configDone);
        sawClear = 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        resetn = 1'b0;
        programClearN = 1'b1;
        cfgWordReady = 1'b1;
        sawCrc = 1'b0;
        sawClear = 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
        t_reset();
        t_load();
        t_start();
        t_cmds();
        t_bypass();
        t_fifo();
        t_start();
        t_clear();
        t_load();
        end_of_test();
    end
endmodule
